//--- sttmr_pkg.sv
// Purpose: Shared constants of the system timer register block
// Assumes: Byte offsets on a plain strobe bus, 32-bit data
// Notes:   Event bit layout is common to all flag and mask registers
package sttmr_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          EVT_W        = 4;
  localparam int          CNT_W        = 20;
  localparam int          PRE_W        = 16;

  localparam logic [7:0]  OFS_PRESCALE = 8'h0c;
  localparam logic [7:0]  OFS_FLAGS    = 8'h10;
  localparam logic [7:0]  OFS_EN_SET   = 8'h14;
  localparam logic [7:0]  OFS_EN_CLR   = 8'h18;
  localparam logic [7:0]  OFS_EN_VIEW  = 8'h1c;
  localparam logic [7:0]  OFS_ALARM    = 8'h20;
  localparam logic [7:0]  OFS_COUNT    = 8'h24;
  localparam logic [7:0]  OFS_FLAG_CLR = 8'h28;

  localparam int          BIT_PERIOD   = 0;
  localparam int          BIT_DOG      = 1;
  localparam int          BIT_TICK     = 2;
  localparam int          BIT_ALARM    = 3;

  localparam logic [15:0] RST_PRESCALE = 16'h8000;
  localparam logic [3:0]  RST_MASK     = 4'h0;
  localparam logic [3:0]  RST_FLAGS    = 4'h0;
  localparam logic [19:0] RST_ALARM    = 20'h00000;
  localparam logic [19:0] RST_COUNT    = 20'h00000;
  localparam logic [16:0] PRE_ZERO_LEN = 17'h10000;

endpackage : sttmr_pkg

//--- sttmr_rtt_core.sv
// Purpose: Prescaler and 20-bit seconds counter
// Assumes: slow_tick is a one-cycle pulse per slow clock period
// Notes:   restart wins over a tick arriving in the same cycle
`timescale 1ns/100ps
module sttmr_rtt_core #(
  parameter int CNT_W = sttmr_pkg::CNT_W,
  parameter int PRE_W = sttmr_pkg::PRE_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             slow_tick,
  input  wire logic             restart,
  input  wire logic [PRE_W-1:0] prescale,
  output logic      [CNT_W-1:0] count,
  output logic                  inc
);
  import sttmr_pkg::*;

  logic [PRE_W:0]   div_ff;
  logic [PRE_W:0]   nxt_div;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             inc_ff;
  logic             nxt_inc;
  logic [PRE_W:0]   period;

  // Zero selects the longest period
  assign period = (prescale == '0) ? PRE_ZERO_LEN : {1'b0, prescale};

  always_comb
  begin
    nxt_div = div_ff;
    nxt_cnt = cnt_ff;
    nxt_inc = 1'b0;
    if (restart)
    begin
      nxt_div = '0;
      nxt_cnt = '0;
    end
    else if (slow_tick)
    begin
      if ((PRE_W+1)'(div_ff + 1'b1) == period)
      begin
        nxt_div = '0;
        nxt_cnt = CNT_W'(cnt_ff + 1'b1);
        nxt_inc = 1'b1;
      end
      else
      begin
        nxt_div = (PRE_W+1)'(div_ff + 1'b1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_ff <= '0;
      cnt_ff <= RST_COUNT;
      inc_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      inc_ff <= nxt_inc;
    end
  end

  assign count = cnt_ff;
  assign inc   = inc_ff;

endmodule : sttmr_rtt_core

//--- sttmr_regs.sv
// Purpose: System timer flags, interrupt mask and seconds timer registers
// Assumes: Period and watchdog zero events arrive as one-cycle pulses
// Notes:   slow_clock is asynchronous and filtered before use
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module sttmr_regs (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        slow_clock,
  input  wire logic                        period_zero,
  input  wire logic                        dog_zero,
  input  wire logic [sttmr_pkg::ADDR_W-1:0] addr,
  input  wire logic [sttmr_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [sttmr_pkg::DATA_W-1:0] rdata,
  output logic                             irq
);
  import sttmr_pkg::*;

  // Slow clock filter
  logic [2:0]        sync_ff;
  logic [2:0]        nxt_sync;
  logic              slow_lvl_ff;
  logic              nxt_slow_lvl;
  logic              slow_tick;

  // Software state
  logic [PRE_W-1:0]  seconds_prescale_count_ff;
  logic [PRE_W-1:0]  nxt_seconds_prescale_count;
  logic [CNT_W-1:0]  alarm_compare_value_ff;
  logic [CNT_W-1:0]  nxt_alarm_compare_value;
  logic [EVT_W-1:0]  mask_ff;
  logic [EVT_W-1:0]  nxt_mask;
  logic [EVT_W-1:0]  flags_ff;
  logic [EVT_W-1:0]  nxt_flags;
  logic              restart_ff;
  logic              nxt_restart;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              irq_ff;
  logic              nxt_irq;

  // Counter core
  logic [CNT_W-1:0]  seconds_count_now;
  logic              seconds_inc;
  logic [EVT_W-1:0]  events;
  logic              alarm_hit;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  function automatic logic [DATA_W-1:0] widen_evt(input logic [EVT_W-1:0] v);
    widen_evt = {{(DATA_W-EVT_W){1'b0}}, v};
  endfunction : widen_evt

  // A change counts only once stages two and three agree
  always_comb
  begin
    nxt_sync     = {sync_ff[1:0], slow_clock};
    nxt_slow_lvl = slow_lvl_ff;
    if (sync_ff[1] == sync_ff[2])
    begin
      nxt_slow_lvl = sync_ff[2];
    end
  end

  assign slow_tick = (sync_ff[1] == sync_ff[2]) & sync_ff[2] & ~slow_lvl_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_ff     <= 3'h0;
      slow_lvl_ff <= 1'b0;
    end
    else
    begin
      sync_ff     <= nxt_sync;
      slow_lvl_ff <= nxt_slow_lvl;
    end
  end

  sttmr_rtt_core #(
    .CNT_W     (CNT_W),
    .PRE_W     (PRE_W)
  ) u_core (
    .clk       (clk),
    .rst_n     (rst_n),
    .slow_tick (slow_tick),
    .restart   (restart_ff),
    .prescale  (seconds_prescale_count_ff),
    .count     (seconds_count_now),
    .inc       (seconds_inc)
  );

  // Matching only on an advance lets zero mean a full wrap of delay
  assign alarm_hit = seconds_inc &
                     (seconds_count_now == alarm_compare_value_ff);

  always_comb
  begin
    events             = '0;
    events[BIT_PERIOD] = period_zero;
    events[BIT_DOG]    = dog_zero;
    events[BIT_TICK]   = seconds_inc;
    events[BIT_ALARM]  = alarm_hit;
  end

  // Register writes
  always_comb
  begin
    nxt_seconds_prescale_count = seconds_prescale_count_ff;
    nxt_alarm_compare_value    = alarm_compare_value_ff;
    nxt_mask                   = mask_ff;
    nxt_restart                = 1'b0;
    if (wr_en)
    begin
      if (hit(addr, OFS_PRESCALE))
      begin
        nxt_seconds_prescale_count = wdata[PRE_W-1:0];
        nxt_restart                = 1'b1;
      end
      if (hit(addr, OFS_ALARM))
      begin
        nxt_alarm_compare_value = wdata[CNT_W-1:0];
      end
      if (hit(addr, OFS_EN_SET))
      begin
        nxt_mask = mask_ff | wdata[EVT_W-1:0];
      end
      if (hit(addr, OFS_EN_CLR))
      begin
        nxt_mask = mask_ff & ~wdata[EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      seconds_prescale_count_ff <= RST_PRESCALE;
      alarm_compare_value_ff    <= RST_ALARM;
      mask_ff                   <= RST_MASK;
      restart_ff                <= 1'b0;
    end
    else
    begin
      seconds_prescale_count_ff <= nxt_seconds_prescale_count;
      alarm_compare_value_ff    <= nxt_alarm_compare_value;
      mask_ff                   <= nxt_mask;
      restart_ff                <= nxt_restart;
    end
  end

  // Flags: a new event in the clearing cycle survives the clear
  always_comb
  begin
    nxt_flags = flags_ff;
    if (rd_en && hit(addr, OFS_FLAGS))
    begin
      nxt_flags = '0;
    end
    if (wr_en && hit(addr, OFS_FLAG_CLR))
    begin
      nxt_flags = flags_ff & ~wdata[EVT_W-1:0];
    end
    nxt_flags = nxt_flags | events;
    nxt_irq   = |(nxt_flags & nxt_mask);
  end

  // Read data valid only in the cycle after the strobe
  always_comb
  begin
    nxt_rdata = '0;
    if (rd_en)
    begin
      unique case (1'b1)
        hit(addr, OFS_PRESCALE):
          nxt_rdata = {{(DATA_W-PRE_W){1'b0}}, seconds_prescale_count_ff};
        hit(addr, OFS_FLAGS):
          nxt_rdata = widen_evt(flags_ff);
        hit(addr, OFS_EN_VIEW):
          nxt_rdata = widen_evt(mask_ff);
        hit(addr, OFS_ALARM):
          nxt_rdata = {{(DATA_W-CNT_W){1'b0}}, alarm_compare_value_ff};
        hit(addr, OFS_COUNT):
          nxt_rdata = {{(DATA_W-CNT_W){1'b0}}, seconds_count_now};
        default:
          nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      flags_ff <= RST_FLAGS;
      rdata_ff <= '0;
      irq_ff   <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  assign rdata = rdata_ff;
  assign irq   = irq_ff;

endmodule : sttmr_regs

//--- sttmr_monitor.sv
// Purpose: Port-level checks of the system timer register block
// Assumes: One clock, synchronous active-low reset
// Notes:   Tick and alarm flags are judged by the bench, not here
`timescale 1ns/100ps
module sttmr_monitor (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         period_zero,
  input wire logic                         dog_zero,
  input wire logic [sttmr_pkg::ADDR_W-1:0] addr,
  input wire logic [sttmr_pkg::DATA_W-1:0] wdata,
  input wire logic                         wr_en,
  input wire logic                         rd_en,
  input wire logic [sttmr_pkg::DATA_W-1:0] rdata,
  input wire logic                         irq
);
  import sttmr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rd_f;
  logic ev;
  assign rd_f = rd_en && addr == OFS_FLAGS;
  assign ev   = period_zero || dog_zero;
  // A flags read in the gap would legally clear the flags, so exclude it
  sequence s_pulse_rd(logic e);
    e ##1 !rd_f ##1 rd_f;
  endsequence
  sequence s_view(logic [7:0] ofs);
    wr_en && addr == ofs ##1 !wr_en ##1 rd_en && addr == OFS_EN_VIEW;
  endsequence
  chk_rdata_idle: assert property (!rd_en |=> rdata == '0)
    else $error("read data not zero outside a read");
  chk_count_upper: assert property (rd_en && addr == OFS_COUNT |=>
    rdata[31:20] == '0) else $error("counter upper bits set");
  chk_flag_upper: assert property (rd_f |=> rdata[31:4] == '0)
    else $error("flag upper bits set");
  chk_period_set: assert property (s_pulse_rd(period_zero) |=>
    rdata[BIT_PERIOD]) else $error("period flag missing");
  chk_dog_set: assert property (s_pulse_rd(dog_zero) |=>
    rdata[BIT_DOG]) else $error("watchdog flag missing");
  chk_read_clear: assert property ((rd_f && !ev) ##1 !ev ##1 rd_f |=>
    rdata[1:0] == 2'h0) else $error("flags not cleared by read");
  chk_irq_on: assert property (wr_en && addr == OFS_EN_SET && wdata[0]
    && period_zero |=> irq) else $error("interrupt did not rise");
  chk_irq_off: assert property (wr_en && addr == OFS_EN_CLR &&
    wdata[3:0] == 4'hf |=> !irq) else $error("interrupt not masked");
  chk_view_set: assert property (s_view(OFS_EN_SET) |=>
    (rdata[3:0] & $past(wdata[3:0], 3)) == $past(wdata[3:0], 3))
    else $error("mask bits not set");
  chk_view_clr: assert property (s_view(OFS_EN_CLR) |=>
    (rdata[3:0] & $past(wdata[3:0], 3)) == 4'h0)
    else $error("mask bits not cleared");
endmodule : sttmr_monitor

bind sttmr_regs sttmr_monitor i_mon (
  .clk         (clk),
  .rst_n       (rst_n),
  .period_zero (period_zero),
  .dog_zero    (dog_zero),
  .addr        (addr),
  .wdata       (wdata),
  .wr_en       (wr_en),
  .rd_en       (rd_en),
  .rdata       (rdata),
  .irq         (irq)
);

//--- testbench.sv
// Purpose: Self-checking bench of the system timer register block
// Assumes: Slow clock far slower than its input filter
// Notes:   Counter wrap after 2^20 ticks is too long to run here
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  import sttmr_pkg::*;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
  } sttmr_row_s;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              slow_clock = 1'b0;
  logic              period_zero = 1'b0;
  logic              dog_zero = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              irq;
  logic [DATA_W-1:0] v;
  int                err_count = 0;
  int                checks_done = 0;
  int                cyc = 0;
  sttmr_row_s        rows [19];
  sttmr_regs i_dut (.clk(clk), .rst_n(rst_n), .slow_clock(slow_clock),
    .period_zero(period_zero), .dog_zero(dog_zero), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq));
  initial forever #10 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {addr, rd_en} <= {a, 1'b1};
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // Read rows hold the expected word in d
  task automatic run_rows(input int n);
    for (int i = 0; i < n; i++)
    begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else
      begin
        rd(rows[i].a);
        `CHK("register", rows[i].d, v);
      end
    end
  endtask : run_rows
  task automatic pulse(input int b, input logic en);
    @(posedge clk);
    {period_zero, dog_zero} <= {b == 0, b == 1};
    {addr, wdata, wr_en} <= {OFS_EN_SET, 32'h1 << b, en};
    @(posedge clk);
    {period_zero, dog_zero, wr_en} <= 3'h0;
    #1;
  endtask : pulse
  task automatic slow(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge clk);
      slow_clock <= 1'b1;
      repeat (8) @(posedge clk);
      slow_clock <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask : slow
  initial
  begin
    rows = '{'{0, OFS_PRESCALE, 32'h8000}, '{0, OFS_EN_VIEW, 0},
      '{0, OFS_ALARM, 0}, '{0, OFS_COUNT, 0}, '{0, OFS_FLAGS, 0},
      '{0, 8'h00, 0}, '{0, OFS_EN_SET, 0}, '{1, OFS_ALARM, 32'hfff12345},
      '{0, OFS_ALARM, 32'h12345}, '{1, OFS_EN_SET, 5}, '{0, OFS_EN_VIEW, 5},
      '{1, OFS_EN_CLR, 4}, '{0, OFS_EN_VIEW, 1}, '{1, OFS_EN_SET, 32'ha},
      '{0, OFS_EN_VIEW, 32'hb}, '{1, OFS_EN_VIEW, 32'hf},
      '{0, OFS_EN_VIEW, 32'hb}, '{1, OFS_EN_CLR, 32'hf}, '{0, OFS_EN_VIEW, 0}};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 `CHK("irq reset", 1'b0, irq);
    run_rows(19);
    for (int b = 0; b < 2; b++)
    begin
      pulse(b, 1'b1);
      `CHK("irq on", 1'b1, irq);
      rd(OFS_FLAGS);
      `CHK("flag set", 32'h1 << b, v);
      rd(OFS_FLAGS);
      `CHK("flag clear", 32'h0, v);
      `CHK("irq off", 1'b0, irq);
      wr(OFS_EN_CLR, 32'hf);
      pulse(b, 1'b0);
      `CHK("irq masked", 1'b0, irq);
      rd(OFS_FLAGS);
      `CHK("masked flag", 32'h1 << b, v);
    end
    // Flag clear register drops only the written ones
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    wr(OFS_FLAG_CLR, 32'h1);
    rd(OFS_FLAGS);
    `CHK("flag clear reg", 32'h2, v);
    wr(OFS_ALARM, 32'h3);
    wr(OFS_EN_SET, 32'hc);
    wr(OFS_PRESCALE, 32'h2);
    rd(OFS_FLAGS);
    slow(6);
    rd(OFS_COUNT);
    `CHK("count", 32'h3, v);
    `CHK("irq tick", 1'b1, irq);
    rd(OFS_FLAGS);
    `CHK("tick alarm", 32'hc, v);
    wr(OFS_PRESCALE, 32'h0);
    rd(OFS_COUNT);
    `CHK("restart", 32'h0, v);
    slow(4);
    rd(OFS_COUNT);
    `CHK("long prescale", 32'h0, v);
    // Leave a live flag and interrupt so the reset has work to do
    pulse(0, 1'b1);
    `CHK("irq before reset", 1'b1, irq);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 `CHK("irq mid reset", 1'b0, irq);
    `CHK("rdata mid reset", 32'h0, rdata);
    run_rows(7);
    complete_run();
  end
endmodule : testbench
